/* File: design/dhar_range_fwd.v */
`timescale 1ns/1ps
`include "dhar_consts.vh"

//Function
// - Enabled proxy mode routes window hits onward
// - Disabled or non-proxy mode routes nothing
// - Window spans FEC-base-00 to FEC-limit-FF
// - Base fields give address bits 19:8
// - Limit fields give address bits 19:8
// - Proxy mode comes from straps, not software
module dhar_range_fwd
(
    input  wire        mclk,          // Clock, 200 MHz
    input  wire        rst,           // Synchronous reset, active high
    input  wire        dualHubStrap,  // Strap: dual hub configuration
    input  wire        legacyStrap,   // Strap: this is the legacy hub
    input  wire        cycValid,      // Inbound memory cycle present
    input  wire [31:0] cycAddr,       // Inbound memory cycle address
    output reg         fwdValid,      // Cycle presented, one cycle late
    output reg  [31:0] fwdAddr,       // Address of the presented cycle
    output reg         fwdToSecond,   // Route this cycle to second hub
    input  wire [31:0] s_axi_awaddr,  // Write address
    input  wire        s_axi_awvalid, // Write address valid
    output reg         s_axi_awready, // Write address ready
    input  wire [31:0] s_axi_wdata,   // Write data
    input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire        s_axi_wvalid,  // Write data valid
    output reg         s_axi_wready,  // Write data ready
    output reg  [1:0]  s_axi_bresp,   // Write response
    output reg         s_axi_bvalid,  // Write response valid
    input  wire        s_axi_bready,  // Write response ready
    input  wire [31:0] s_axi_araddr,  // Read address
    input  wire        s_axi_arvalid, // Read address valid
    output reg         s_axi_arready, // Read address ready
    output reg  [31:0] s_axi_rdata,   // Read data
    output reg  [1:0]  s_axi_rresp,   // Read response
    output reg         s_axi_rvalid,  // Read data valid
    input  wire        s_axi_rready   // Read data ready
);

    ////////////////////////////////////////////////////////////////////////
    // Register address decode, shared by read and write paths
    function [1:0] regSel;
        input [31:0] a;
        begin
            if (a[11:2] == `DHAR_IDX_BASE)
                regSel = `DHAR_SEL_BASE;
            else if (a[11:2] == `DHAR_IDX_LIMIT)
                regSel = `DHAR_SEL_LIMIT;
            else if (a[11:2] == `DHAR_IDX_STATUS)
                regSel = `DHAR_SEL_STATUS;
            else
                regSel = `DHAR_SEL_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    reg         winEnable;   // Window enable bit of the base register
    reg  [11:0] winBase;     // Base fields, address bits 19:8
    reg  [11:0] winLimit;    // Limit fields, address bits 19:8
    reg         strapDual;   // Captured dual hub strap
    reg         strapLegacy; // Captured legacy hub strap
    reg         awHeld;      // Write address accepted, awaiting data
    reg  [31:0] awAddr;      // Accepted write address
    reg         wHeld;       // Write data accepted, awaiting address
    reg  [31:0] wData;       // Accepted write data
    reg  [3:0]  wStrb;       // Accepted write strobes
    wire        proxyMode;   // Legacy hub in dual hub proxy mode
    wire        winActive;   // Window may route cycles
    wire        winHit;      // Current address inside window
    wire [15:0] baseRead;    // Read view of base register
    wire [15:0] limitRead;   // Read view of limit register
    wire [15:0] statusRead;  // Read view of status register
    wire [1:0]  wSel;        // Selector for pending write

    ////////////////////////////////////////////////////////////////////////
    // Straps are sampled while reset is held and frozen at its release,
    // so software can never change the mode
    always @(posedge mclk)
    begin
        if (rst)
        begin
            strapDual   <= dualHubStrap;
            strapLegacy <= legacyStrap;
        end
    end

    assign proxyMode = strapDual && strapLegacy;
    assign winActive = winEnable && proxyMode;

    ////////////////////////////////////////////////////////////////////////
    // Window compare
    dhar_window_cmp u_cmp
    (
        .addr  (cycAddr),
        .base  (winBase),
        .limit (winLimit),
        .hit   (winHit)
    );

    ////////////////////////////////////////////////////////////////////////
    // Routing decision, registered so outputs come from flops
    always @(posedge mclk)
    begin
        if (rst)
        begin
            fwdValid    <= 1'b0;
            fwdAddr     <= 32'h00000000;
            fwdToSecond <= 1'b0;
        end
        else
        begin
            fwdValid    <= cycValid;
            fwdAddr     <= cycAddr;
            fwdToSecond <= cycValid && winHit && winActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read views; reserved bits read as zero
    assign baseRead   = {winEnable, 3'h0, winBase};
    assign limitRead  = {4'h0, winLimit};
    assign statusRead = {12'h000, winActive, strapLegacy, strapDual,
                         proxyMode};
    assign wSel       = regSel(awAddr);

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order or in the same
    // cycle, one write at a time; the response follows once both are in hand
    always @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DHAR_RESP_OKAY;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 32'h00000000;
            wData         <= 32'h00000000;
            wStrb         <= 4'h0;
            winEnable     <= 1'b0;
            winBase       <= `DHAR_FLD_RESET;
            winLimit      <= `DHAR_FLD_RESET;
        end
        else
        begin
            s_axi_awready <= !awHeld && !s_axi_bvalid &&
                             !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !wHeld && !s_axi_bvalid &&
                             !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (awHeld && wHeld && !s_axi_bvalid)
            begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wSel == `DHAR_SEL_NONE) ?
                                `DHAR_RESP_SLVERR : `DHAR_RESP_OKAY;
                // Status is read-only; writes to it are accepted and dropped
                if (wSel == `DHAR_SEL_BASE)
                begin
                    if (wStrb[0])
                        winBase[7:0] <= wData[7:0];
                    if (wStrb[1])
                    begin
                        winBase[11:8] <= wData[11:8];
                        winEnable <= wData[`DHAR_EN_BIT];
                    end
                end
                if (wSel == `DHAR_SEL_LIMIT)
                begin
                    if (wStrb[0])
                        winLimit[7:0] <= wData[7:0];
                    if (wStrb[1])
                        winLimit[11:8] <= wData[11:8];
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one read at a time, data registered at acceptance
    always @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DHAR_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid &&
                             !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `DHAR_RESP_OKAY;
                case (regSel(s_axi_araddr))
                    `DHAR_SEL_BASE:   s_axi_rdata <= {16'h0000, baseRead};
                    `DHAR_SEL_LIMIT:  s_axi_rdata <= {16'h0000, limitRead};
                    `DHAR_SEL_STATUS: s_axi_rdata <= {16'h0000, statusRead};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `DHAR_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

/* File: design/dhar_consts.vh */
`ifndef DHAR_CONSTS_VH
`define DHAR_CONSTS_VH

// Register indices; byte address is four times the index
`define DHAR_IDX_BASE       10'h148
`define DHAR_IDX_LIMIT      10'h14a
`define DHAR_IDX_STATUS     10'h14c

// Register selector codes
`define DHAR_SEL_NONE       2'h0
`define DHAR_SEL_BASE       2'h1
`define DHAR_SEL_LIMIT      2'h2
`define DHAR_SEL_STATUS     2'h3

// Field layout of the window registers
`define DHAR_EN_BIT         15
`define DHAR_FLD_MSB        11
`define DHAR_FLD_LSB        0
`define DHAR_FLD_W          12
`define DHAR_REG_RESET      16'h0000
`define DHAR_FLD_RESET      12'h000

// Fixed upper pattern of the window, address bits 31:20
`define DHAR_FIXED_HI       12'hfec
`define DHAR_HI_MSB         31
`define DHAR_HI_LSB         20
`define DHAR_MID_MSB        19
`define DHAR_MID_LSB        8

// AXI4-Lite responses
`define DHAR_RESP_OKAY      2'h0
`define DHAR_RESP_SLVERR    2'h2

`endif

/* File: design/dhar_window_cmp.v */
`timescale 1ns/1ps
`include "dhar_consts.vh"

// Inclusive window compare; a limit below the base matches nothing
module dhar_window_cmp
(
    input  wire [31:0] addr,    // Inbound memory address
    input  wire [11:0] base,    // Window base, address bits 19:8
    input  wire [11:0] limit,   // Window limit, address bits 19:8
    output wire        hit      // Address lies inside the window
);

    ////////////////////////////////////////////////////////////////////////
    // Upper bits fixed, middle bits between base and limit
    wire hiMatch;
    wire midMatch;

    assign hiMatch  = (addr[`DHAR_HI_MSB:`DHAR_HI_LSB] == `DHAR_FIXED_HI);
    assign midMatch = (addr[`DHAR_MID_MSB:`DHAR_MID_LSB] >= base) &&
                      (addr[`DHAR_MID_MSB:`DHAR_MID_LSB] <= limit);
    assign hit      = hiMatch && midMatch;

endmodule

/* File: tb/dhar_second_hub.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module dhar_second_hub
(
    input  wire        mclk,        // Clock
    input  wire        rst,         // Reset, active high
    input  wire        fwdValid,    // Cycle presented
    input  wire        fwdToSecond, // Cycle routed here
    output logic [7:0] hitCount     // Cycles taken
);
    // Takes every routed cycle; the link has no backpressure to model
    always @(posedge mclk)
        if (rst)
            hitCount <= 8'h00;
        else if (fwdValid && fwdToSecond)
            hitCount <= hitCount + 8'h01;
endmodule

/* File: tb/dhar_range_fwd_properties.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module dhar_fwd_props
(
    input wire        mclk,          // Clock
    input wire        rst,           // Reset
    input wire        cycValid,      // Inbound cycle
    input wire [31:0] cycAddr,       // Inbound address
    input wire        fwdValid,      // Presented cycle
    input wire [31:0] fwdAddr,       // Presented address
    input wire        fwdToSecond,   // Routed onward
    input wire        s_axi_awready, // Write address ready
    input wire        s_axi_wready,  // Write data ready
    input wire        s_axi_bvalid,  // Write response valid
    input wire        s_axi_bready,  // Write response ready
    input wire        s_axi_arvalid, // Read address valid
    input wire        s_axi_arready, // Read address ready
    input wire        s_axi_rvalid,  // Read data valid
    input wire        s_axi_rready   // Read data ready
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_cycle_delay: assert property (cycValid |=> fwdValid &&
        fwdAddr == $past(cycAddr)) else $error("cycle not presented");
    a_idle_quiet: assert property (!cycValid |=> !fwdValid)
        else $error("spurious cycle");
    a_route_valid: assert property (fwdToSecond |-> fwdValid)
        else $error("route without cycle");
    a_fixed_high: assert property (fwdToSecond |->
        fwdAddr[31:20] == 12'hfec) else $error("route outside FEC");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_read_done: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid) else $error("read answer repeated");
    a_write_done: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("write answer repeated");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while answering");
    a_wdata_block: assert property (s_axi_bvalid |-> !s_axi_wready)
        else $error("write data taken while answering");
    c_route: cover property (fwdToSecond);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind dhar_range_fwd dhar_fwd_props u_props (.mclk, .rst, .cycValid,
    .cycAddr, .fwdValid, .fwdAddr, .fwdToSecond, .s_axi_awready,
    .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready);

/* File: tb/tb_dual_hub_apic_range_forward.sv */
`timescale 1ns/1ps
`include "dhar_consts.vh"
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////////
module tb_dual_hub_apic_range_forward;
    logic        mclk = 0, rst = 1, dualHubStrap = 1, legacyStrap = 1;
    logic        cycValid = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] cycAddr = 0, s_axi_awaddr = 0, s_axi_wdata = 0;
    logic [31:0] s_axi_araddr = 0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    wire         fwdValid, fwdToSecond, s_axi_awready, s_axi_wready;
    wire         s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [31:0] fwdAddr, s_axi_rdata;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [7:0]  hitCount;
    logic [1:0]  r;
    logic [31:0] q;
    int          errors = 0, totalChecks = 0;
    // Window fec12300..fec134ff: both edges and one step past each
    logic [31:0] adr [5] = '{32'hfec122ff, 32'hfec12300, 32'hfec134ff,
                             32'hfec13500, 32'hfed12300};
    logic        hit [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    dhar_range_fwd dut_u (.mclk, .rst, .dualHubStrap, .legacyStrap,
        .cycValid, .cycAddr, .fwdValid, .fwdAddr, .fwdToSecond,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    dhar_second_hub hub_u (.mclk, .rst, .fwdValid, .fwdToSecond, .hitCount);
    always #2.5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    // One bus access; each valid drops only at the edge its ready is seen
    task automatic acc(input logic wr, input logic [31:0] a, d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready)
                s_axi_awvalid <= 0;
            if (s_axi_wready)
                s_axi_wvalid <= 0;
            if (s_axi_arready)
                s_axi_arvalid <= 0;
        end while (!(wr ? s_axi_bvalid : s_axi_rvalid));
        r = wr ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        s_axi_bready <= 0;
        s_axi_rready <= 0;
    endtask
    // Present a cycle and look at the route one clock later
    task automatic cyc(input logic [31:0] a, input logic e);
        @(posedge mclk);
        cycValid <= 1;
        cycAddr <= a;
        @(posedge mclk);
        cycValid <= 0;
        #1;
        `CHK(fwdToSecond, e)
    endtask
    // Straps are only taken while reset is held
    // Reset is raised at an edge and seen high at three edges
    task automatic reset_dut(input logic d);
        @(posedge mclk);
        dualHubStrap <= d;
        rst <= 1;
        repeat (3) @(posedge mclk);
        rst <= 0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", totalChecks, errors);
        if (errors == 0 && totalChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        reset_dut(1);
        acc(0, 32'h520, 0);
        `CHK(q, 32'h0)
        acc(0, 32'h528, 0);
        `CHK(q, 32'h0)
        acc(0, 32'h600, 0);
        `CHK(r, `DHAR_RESP_SLVERR)
        // Status is read-only: a write is answered and changes nothing
        acc(1, 32'h530, 32'h0);
        `CHK(r, `DHAR_RESP_OKAY)
        acc(0, 32'h530, 0);
        `CHK(q, 32'h7)
        $display("test done: reset values");
        acc(1, 32'h520, 32'h0123);
        acc(1, 32'h528, 32'h0134);
        for (int i = 0; i < 5; i++)
            cyc(adr[i], 1'b0);
        acc(1, 32'h520, 32'h8123);
        `CHK(r, `DHAR_RESP_OKAY)
        acc(0, 32'h520, 0);
        `CHK(q, 32'h8123)
        for (int i = 0; i < 5; i++)
            cyc(adr[i], hit[i]);
        `CHK(hitCount, 8'h02)
        acc(1, 32'h528, 32'h0122);
        cyc(32'hfec12300, 1'b0);
        // Low byte strobe only: limit bits 11:8 keep their value
        s_axi_wstrb <= 4'h1;
        acc(1, 32'h528, 32'h0f34);
        s_axi_wstrb <= 4'hf;
        acc(0, 32'h528, 0);
        `CHK(q, 32'h0134)
        $display("test done: window edges");
        reset_dut(0);
        acc(1, 32'h520, 32'h8123);
        acc(1, 32'h528, 32'h0134);
        for (int i = 0; i < 5; i++)
            cyc(adr[i], 1'b0);
        `CHK(hitCount, 8'h00)
        acc(0, 32'h530, 0);
        `CHK(q, 32'h4)
        $display("test done: proxy mode off");
        report_and_stop;
    end
    // Whole run is some 100 clocks; this cuts a hang short
    initial
    begin
        #20000;
        errors++;
        report_and_stop;
    end
endmodule
